// >>> shared/psw_pkg.sv
// Constants for the program status word execution and exception fields.
// Assumes a core that drives move, transfer and exception events in its clock domain.
package psw_pkg;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned SAT_BIT = 27;
  localparam int unsigned CMP_BIT = 24;
  localparam int unsigned XHI_LSB = 25;
  localparam int unsigned XLO_LSB = 10;
  localparam int unsigned EXC_W = 6;

  // ************************************************************
  // Reset values and masks
  // ************************************************************
  localparam logic [31:0] PSW_RESET = 32'h0100_0000;
  localparam logic [31:0] FLAG_MASK = 32'hF800_0000;
  localparam logic [31:0] EXEC_MASK = 32'h0700_FC00;
  localparam logic [31:0] EXC_MASK = 32'h0000_003F;
  localparam logic [5:0] EXC_RESET = 6'h00;
  localparam logic [7:0] XST_RESET = 8'h00;
  localparam logic [5:0] EXC_MAX_VALID = 6'h3B;

  // ************************************************************
  // Exception numbers
  // ************************************************************
  localparam logic [5:0] EXC_THREAD = 6'h00;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_HARD = 6'h03;
  localparam logic [5:0] EXC_MEMMGMT = 6'h04;
  localparam logic [5:0] EXC_BUS = 6'h05;
  localparam logic [5:0] EXC_USAGE = 6'h06;
  localparam logic [5:0] EXC_SUPERVISOR = 6'h0B;
  localparam logic [5:0] EXC_PENDED = 6'h0E;
  localparam logic [5:0] EXC_TICK = 6'h0F;
  localparam logic [5:0] EXC_IRQ0 = 6'h10;

  // View select for a move: one bit each for flags, exec, interrupt
  localparam logic [2:0] VIEW_FLAG = 3'h1;
  localparam logic [2:0] VIEW_EXEC = 3'h2;
  localparam logic [2:0] VIEW_INT = 3'h4;

  // Execution-state machine: idle, transfer resume or conditional block
  typedef enum logic [2:0] {
    XS_IDLE = 3'b001,
    XS_RESUME = 3'b010,
    XS_COND = 3'b100
  } xfer_state_t;

  // Execution-state fields packed as {hi[1:0], lo[5:0]}
  function automatic logic [31:0] pack_exec(input logic cmp, input logic [7:0] xst);
    pack_exec = {5'h00, xst[7:6], cmp, 8'h00, xst[5:0], 10'h000};
  endfunction

  function automatic logic [7:0] unpack_exec(input logic [31:0] w);
    unpack_exec = {w[XHI_LSB+1:XHI_LSB], w[XLO_LSB+5:XLO_LSB]};
  endfunction

endpackage

// >>> rtl/psw_exc_num.sv
// Active exception number holder.
// Assumes the core gives entry and return strobes; return carries the stacked word.
`timescale 1ns/1ps
module psw_exc_num
  import psw_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_exc_entry,
  input wire logic [5:0] i_entry_num,
  input wire logic i_exc_return,
  input wire logic [31:0] i_stacked_psw,
  output logic [5:0] o_exc_num
);

  logic [5:0] exc_num;
  logic [5:0] next_exc_num;

  // Writes from any move instruction never reach here
  always_comb begin
    next_exc_num = exc_num;
    if (i_exc_entry) begin
      next_exc_num = i_entry_num;
    end else if (i_exc_return) begin
      next_exc_num = i_stacked_psw[EXC_W-1:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      exc_num <= EXC_RESET;
    end else begin
      exc_num <= next_exc_num;
    end
  end

  assign o_exc_num = exc_num;

  a_entry_loads: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_exc_entry |=> exc_num == $past(i_entry_num))
    else $error("exception number not loaded on entry");

endmodule

// >>> rtl/psw_exec_fields.sv
// Execution-state, compact-state and exception fields of the program status word.
// Assumes the core issues single-cycle event strobes and obeys o_exec_fault.
`timescale 1ns/1ps
module psw_exec_fields
  import psw_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_move_wr,
  input wire logic i_move_rd,
  input wire logic [2:0] i_move_view,
  input wire logic i_privileged,
  input wire logic [31:0] i_move_wdata,
  input wire logic i_set_sat,
  input wire logic [4:0] i_flags_in,
  input wire logic i_flags_we,
  input wire logic i_xfer_irq,
  input wire logic [3:0] i_xfer_next_reg,
  input wire logic i_xfer_resume_take,
  input wire logic i_cond_start,
  input wire logic [7:0] i_cond_code,
  input wire logic i_cond_advance,
  input wire logic i_exchange_branch,
  input wire logic i_exchange_bit,
  input wire logic i_exc_entry,
  input wire logic [5:0] i_entry_num,
  input wire logic i_vector_load,
  input wire logic i_vector_bit,
  input wire logic i_exc_return,
  input wire logic [31:0] i_stacked_psw,
  input wire logic i_exec_attempt,
  output logic [31:0] o_move_rdata,
  output logic [31:0] o_psw,
  output logic o_resume_valid,
  output logic [3:0] o_resume_reg,
  output logic o_exec_fault
);

  // ************************************************************
  // State
  // ************************************************************
  logic [4:0] flags;
  logic [4:0] next_flags;
  logic cmp_bit;
  logic next_cmp_bit;
  logic [7:0] xst;
  logic [7:0] next_xst;
  xfer_state_t state;
  xfer_state_t next_state;
  logic [31:0] move_rdata;
  logic [31:0] next_move_rdata;
  logic [31:0] psw;
  logic [31:0] next_psw;
  logic exec_fault;
  logic next_exec_fault;
  logic resume_valid;
  logic next_resume_valid;
  logic [5:0] exc_num;

  psw_exc_num u_exc (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_exc_entry(i_exc_entry),
    .i_entry_num(i_entry_num),
    .i_exc_return(i_exc_return),
    .i_stacked_psw(i_stacked_psw),
    .o_exc_num(exc_num)
  );

  // ************************************************************
  // Flags: only the flag view is writable by a move
  // ************************************************************
  always_comb begin
    next_flags = flags;
    if (i_exc_return) begin
      next_flags = i_stacked_psw[31:27];
    end else if (i_move_wr && (i_move_view & VIEW_FLAG) != 3'h0) begin
      next_flags = i_move_wdata[31:27];
    end else if (i_flags_we) begin
      next_flags = {i_flags_in[4:1], flags[0] | i_flags_in[0]};
    end
    // Saturation set wins over a clearing write in the same cycle
    if (i_set_sat) begin
      next_flags[0] = 1'b1;
    end
  end

  // ************************************************************
  // Execution state: transfer resume or conditional block
  // ************************************************************
  always_comb begin
    next_state = state;
    next_xst = xst;
    next_cmp_bit = cmp_bit;
    case (state)
      XS_IDLE: begin
        if (i_xfer_irq) begin
          next_xst = {2'b00, i_xfer_next_reg, 2'b00};
          next_state = XS_RESUME;
        end else if (i_cond_start) begin
          next_xst = i_cond_code;
          next_state = XS_COND;
        end
      end
      XS_RESUME: begin
        if (i_xfer_resume_take) begin
          next_xst = XST_RESET;
          next_state = XS_IDLE;
        end
      end
      XS_COND: begin
        // Shift the mask; block ends when the low three bits run empty
        if (i_cond_advance) begin
          if (xst[2:0] == 3'b000) begin
            next_xst = XST_RESET;
            next_state = XS_IDLE;
          end else begin
            next_xst = {xst[7:5], xst[4:0] << 1};
          end
        end
      end
      default: begin
        next_state = XS_IDLE;
        next_xst = XST_RESET;
      end
    endcase
    if (i_exc_return) begin
      next_xst = unpack_exec(i_stacked_psw);
      next_state = (next_xst == XST_RESET) ? XS_IDLE
        : (next_xst[7:6] == 2'b00 && next_xst[1:0] == 2'b00) ? XS_RESUME : XS_COND;
    end
    // Compact bit has only these sources; moves never touch it
    if (i_exchange_branch) begin
      next_cmp_bit = i_exchange_bit;
    end else if (i_exc_return) begin
      next_cmp_bit = i_stacked_psw[CMP_BIT];
    end else if (i_vector_load) begin
      next_cmp_bit = i_vector_bit;
    end
  end

  // ************************************************************
  // Read port, status image and fault
  // ************************************************************
  always_comb begin
    next_psw = {next_flags, 27'h0} | pack_exec(next_cmp_bit, next_xst)
      | {26'h0, exc_num};
    next_move_rdata = 32'h0000_0000;
    if (i_move_rd) begin
      if ((i_move_view & VIEW_FLAG) != 3'h0) begin
        next_move_rdata = next_move_rdata | (psw & FLAG_MASK);
      end
      if ((i_move_view & VIEW_INT) != 3'h0 && i_privileged) begin
        next_move_rdata = next_move_rdata | (psw & EXC_MASK);
      end
      // Execution bits never surface through a move read
      next_move_rdata = next_move_rdata & ~EXEC_MASK;
    end
    next_exec_fault = i_exec_attempt && !cmp_bit;
    // Registered copy so the output comes straight from a flop
    next_resume_valid = next_state == XS_RESUME;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      flags <= 5'h00;
      cmp_bit <= PSW_RESET[CMP_BIT];
      xst <= XST_RESET;
      state <= XS_IDLE;
      move_rdata <= 32'h0000_0000;
      psw <= PSW_RESET;
      exec_fault <= 1'b0;
      resume_valid <= 1'b0;
    end else begin
      flags <= next_flags;
      cmp_bit <= next_cmp_bit;
      xst <= next_xst;
      state <= next_state;
      move_rdata <= next_move_rdata;
      psw <= next_psw;
      exec_fault <= next_exec_fault;
      resume_valid <= next_resume_valid;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_move_rdata = move_rdata;
  assign o_psw = psw;
  assign o_resume_valid = resume_valid;
  assign o_resume_reg = xst[5:2];
  assign o_exec_fault = exec_fault;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_irq_hold;
    i_xfer_irq && state == XS_IDLE && !i_exc_return;
  endsequence

  a_sat_sticky: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    flags[0] && !i_move_wr && !i_exc_return |=> flags[0])
    else $error("saturation flag cleared itself");
  a_resume_record: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_irq_hold |=> o_resume_valid && o_resume_reg == $past(i_xfer_next_reg))
    else $error("next register index not recorded");
  a_resume_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    state == XS_RESUME |-> xst[7:6] == 2'b00 && xst[1:0] == 2'b00)
    else $error("resumable state has nonzero high or low bits");
  a_resume_done: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    state == XS_RESUME && i_xfer_resume_take && !i_exc_return |=> state == XS_IDLE)
    else $error("resume not completed");
  a_cmp_quiet: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !i_exchange_branch && !i_exc_return && !i_vector_load |=> cmp_bit == $past(cmp_bit))
    else $error("compact bit changed without cause");
  a_fault_raise: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_exec_attempt && !cmp_bit |=> o_exec_fault)
    else $error("no fault when executing with compact bit clear");
  a_reserved_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    psw[23:16] == 8'h00 && psw[9:6] == 4'h0)
    else $error("reserved bits nonzero");
  a_exec_hidden: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_move_rd |=> (o_move_rdata & EXEC_MASK) == 32'h0000_0000)
    else $error("execution bits visible to move read");
  a_excnum_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_move_wr && !i_exc_entry && !i_exc_return |=> exc_num == $past(exc_num))
    else $error("move write changed exception number");
  a_reset_image: assert property (@(posedge i_mclk)
    $past(i_sys_rst) |-> psw == PSW_RESET)
    else $error("status word reset value wrong");

endmodule

// >>> dv/program_status_exec_fields_tb_top.sv
// Self-checking bench for the status word execution and exception fields.
// Assumes strobes are one-cycle pulses taken on the rising edge of i_mclk.
`timescale 1ns/1ps
module program_status_exec_fields_tb_top;
  import psw_pkg::*;

  // ************************************************************
  // Stimulus signals
  // ************************************************************
  logic i_mclk, i_sys_rst, i_move_wr, i_move_rd, i_privileged, i_set_sat, i_flags_we;
  logic i_xfer_irq, i_xfer_resume_take, i_cond_start, i_cond_advance, i_exchange_branch;
  logic i_exchange_bit, i_exc_entry, i_vector_load, i_vector_bit, i_exc_return;
  logic i_exec_attempt, o_resume_valid, o_exec_fault;
  logic [2:0] i_move_view;
  logic [31:0] i_move_wdata, i_stacked_psw, o_move_rdata, o_psw;
  logic [4:0] i_flags_in;
  logic [3:0] i_xfer_next_reg, o_resume_reg;
  logic [7:0] i_cond_code;
  logic [5:0] i_entry_num;
  logic [5:0] codes [10];
  int error_cnt, num_checks;

  psw_exec_fields u_psw_exec_fields (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_move_wr(i_move_wr), .i_move_rd(i_move_rd), .i_move_view(i_move_view),
    .i_privileged(i_privileged), .i_move_wdata(i_move_wdata), .i_set_sat(i_set_sat),
    .i_flags_in(i_flags_in), .i_flags_we(i_flags_we), .i_xfer_irq(i_xfer_irq),
    .i_xfer_next_reg(i_xfer_next_reg), .i_xfer_resume_take(i_xfer_resume_take),
    .i_cond_start(i_cond_start), .i_cond_code(i_cond_code),
    .i_cond_advance(i_cond_advance), .i_exchange_branch(i_exchange_branch),
    .i_exchange_bit(i_exchange_bit), .i_exc_entry(i_exc_entry),
    .i_entry_num(i_entry_num), .i_vector_load(i_vector_load),
    .i_vector_bit(i_vector_bit), .i_exc_return(i_exc_return),
    .i_stacked_psw(i_stacked_psw), .i_exec_attempt(i_exec_attempt),
    .o_move_rdata(o_move_rdata), .o_psw(o_psw), .o_resume_valid(o_resume_valid),
    .o_resume_reg(o_resume_reg), .o_exec_fault(o_exec_fault));

  // ************************************************************
  // Helpers
  // ************************************************************
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  // Inputs always move 1 ns after the edge, clear of sampling
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_moves();
    chk(o_psw, 32'h0100_0000);
    i_privileged = 1'b1; i_move_wr = 1'b1; i_move_view = 3'h7; i_move_wdata = 32'hFFFF_FFFF;
    step(1);
    i_move_wr = 1'b0;
    step(1);
    chk(o_psw, 32'hF900_0000);
    i_privileged = 1'b0; i_move_rd = 1'b1;
    step(1);
    i_move_rd = 1'b0;
    chk(o_move_rdata, 32'hF800_0000);
  endtask

  task automatic t_sat();
    i_move_wr = 1'b1; i_move_view = VIEW_FLAG; i_move_wdata = 32'h0000_0000;
    step(1);
    i_move_wr = 1'b0; i_set_sat = 1'b1;
    step(1);
    i_set_sat = 1'b0;
    step(6);
    chk(o_psw[31:24], 8'h09);
    i_flags_we = 1'b1; i_flags_in = 5'h14;
    step(1);
    i_flags_we = 1'b0;
    chk(o_psw, 32'hA900_0000);
    i_move_wr = 1'b1; i_set_sat = 1'b1;
    step(1);
    i_move_wr = 1'b0; i_set_sat = 1'b0;
    chk(o_psw, 32'h0900_0000);
    i_move_wr = 1'b1;
    step(1);
    i_move_wr = 1'b0;
    step(1);
    chk(o_psw, 32'h0100_0000);
  endtask

  task automatic t_xfer();
    i_xfer_irq = 1'b1; i_xfer_next_reg = 4'h5;
    step(1);
    i_xfer_irq = 1'b0;
    chk({o_resume_valid, o_resume_reg}, 5'h15);
    step(1);
    chk(o_psw, 32'h0100_5000);
    i_xfer_resume_take = 1'b1;
    step(1);
    i_xfer_resume_take = 1'b0;
    chk(o_resume_valid, 1'b0);
  endtask

  task automatic t_cond();
    i_cond_start = 1'b1; i_cond_code = 8'h44;
    step(1);
    i_cond_start = 1'b0;
    step(1);
    chk(o_psw, 32'h0300_1000);
    i_cond_advance = 1'b1;
    step(1);
    chk(o_psw, 32'h0300_2000);
    step(1);
    i_cond_advance = 1'b0;
    chk(o_psw, 32'h0100_0000);
    i_exc_return = 1'b1; i_stacked_psw = 32'h0100_5000;
    step(1);
    i_exc_return = 1'b0;
    chk({o_resume_valid, o_resume_reg}, 5'h15);
    chk(o_psw, 32'h0100_5000);
    i_xfer_resume_take = 1'b1;
    step(1);
    i_xfer_resume_take = 1'b0;
    chk(o_psw, 32'h0100_0000);
  endtask

  task automatic t_exc();
    codes = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0B, 6'h0E, 6'h0F, 6'h10, 6'h3B};
    foreach (codes[k]) begin
      i_exc_entry = 1'b1; i_entry_num = codes[k];
      step(1);
      i_exc_entry = 1'b0;
      step(1);
      chk(o_psw, {26'h004_0000, codes[k]});
    end
    i_privileged = 1'b1; i_move_rd = 1'b1; i_move_view = VIEW_INT;
    step(1);
    i_move_rd = 1'b0;
    chk(o_move_rdata, 32'h0000_003B);
    i_exc_return = 1'b1; i_stacked_psw = 32'h0100_0006;
    step(1);
    i_exc_return = 1'b0;
    step(1);
    chk(o_psw[5:0], 6'h06);
  endtask

  task automatic t_compact();
    i_exec_attempt = 1'b1;
    step(1);
    i_exec_attempt = 1'b0;
    chk(o_exec_fault, 1'b0);
    i_exchange_branch = 1'b1; i_exchange_bit = 1'b0;
    step(1);
    i_exchange_branch = 1'b0;
    step(1);
    chk(o_psw[24], 1'b0);
    i_exec_attempt = 1'b1;
    step(1);
    i_exec_attempt = 1'b0;
    chk(o_exec_fault, 1'b1);
    i_vector_load = 1'b1; i_vector_bit = 1'b1;
    step(1);
    i_vector_load = 1'b0;
    step(1);
    chk(o_psw[24], 1'b1);
    i_exc_return = 1'b1; i_stacked_psw = 32'h0000_0000;
    step(1);
    i_exc_return = 1'b0;
    chk(o_psw[24], 1'b0);
  endtask

  // Reset in mid-run must clear a held transfer and the exception number
  task automatic t_reset();
    i_xfer_irq = 1'b1; i_xfer_next_reg = 4'hA; i_exc_entry = 1'b1; i_entry_num = 6'h10;
    step(1);
    i_xfer_irq = 1'b0; i_exc_entry = 1'b0;
    step(1);
    chk(o_psw, 32'h0000_A010);
    i_sys_rst = 1'b1;
    step(2);
    i_sys_rst = 1'b0;
    chk(o_psw, 32'h0100_0000);
    chk(o_resume_valid, 1'b0);
  endtask

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    error_cnt = 0; num_checks = 0;
    {i_move_wr, i_move_rd, i_privileged, i_set_sat, i_flags_we, i_xfer_irq} = '0;
    {i_xfer_resume_take, i_cond_start, i_cond_advance, i_exchange_branch} = '0;
    {i_exchange_bit, i_exc_entry, i_vector_load, i_vector_bit, i_exc_return} = '0;
    {i_exec_attempt, i_move_view, i_move_wdata, i_stacked_psw} = '0;
    {i_flags_in, i_xfer_next_reg, i_cond_code, i_entry_num} = '0;
    i_sys_rst = 1'b1;
    step(12);
    i_sys_rst = 1'b0;
    t_moves();
    t_sat();
    t_xfer();
    t_cond();
    t_exc();
    t_compact();
    t_reset();
    results();
  end

  // Whole run is near 70 cycles; allow a wide margin
  initial begin
    #4000;
    error_cnt++;
    results();
  end
endmodule
